// >>> hdl/gpio_expander_defs.svh
// Constants for the two-port serial I/O expander
`ifndef GPIO_EXPANDER_DEFS_SVH
`define GPIO_EXPANDER_DEFS_SVH

// ****************************************************
// Register pointer values
// ****************************************************
`define REG_IN0 3'h0
`define REG_IN1 3'h1
`define REG_OUT0 3'h2
`define REG_OUT1 3'h3
`define REG_POL0 3'h4
`define REG_POL1 3'h5
`define REG_CFG0 3'h6
`define REG_CFG1 3'h7

// ****************************************************
// Reset values
// ****************************************************
`define CFG_RESET 8'hff
`define OUT_RESET 8'hff
`define POL_RESET 8'h00

// ****************************************************
// Serial framing and timing
// ****************************************************
`define BITS_PER_BYTE 4'h8
// Eight data bits plus the acknowledge slot
`define BITS_PER_SLOT 4'h9
`define ADDR_BASE_DEFAULT 7'h2a
`define SCL_MAX_KHZ 400
`define CLK_MHZ 125
`define PRIME_CYCLES 2'h3

`endif

// >>> hdl/gpio_expander_pkg.sv
// Types shared by the serial I/O expander
package gpio_expander_pkg;

    // Serial slave states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_CMD = 4'b0011,
        ST_CMD_ACK = 4'b0100,
        ST_WR = 4'b0101,
        ST_WR_ACK = 4'b0110,
        ST_RD = 4'b0111,
        ST_RD_ACK = 4'b1000
    } slave_state_t;

endpackage : gpio_expander_pkg

// >>> hdl/bit_sync.sv
// Two-flop synchroniser for pins entering the clk domain
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // ****************************************************
    // Synchroniser chain
    // ****************************************************
    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= {WIDTH{RESET_VAL}};
            sync_out <= {WIDTH{RESET_VAL}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : bit_sync

`default_nettype wire

// >>> hdl/gpio_expander.sv
// Sixteen-line serial-controlled I/O expander with interrupt
// Summary of operation
// - Two 8-bit ports, four registers each
// - All lines inputs, drivers off after reset
// - Direction bits select drive or receive
// - Input sampled, outputs latched until rewritten
// - Polarity bit inverts reported input value
// - Every register readable over serial bus
// - Reset loads defaults, slave goes idle
// - Reset pin repeats power-on initialisation
// - Interrupt when input differs from register
// - Interrupt open-drain, active low
// - Address select picks one of two addresses
// - Serial bus works up to 400 kHz
`timescale 1ns/1ps
`default_nettype none
`include "gpio_expander_defs.svh"

module gpio_expander #(
    parameter logic [6:0] ADDR_BASE = `ADDR_BASE_DEFAULT,
    parameter int LINES = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_sel,
    input wire logic [LINES-1:0] port_in,
    output logic [LINES-1:0] port_out,
    output logic [LINES-1:0] port_oe,
    output logic int_n_o,
    output logic int_n_oe
);

    // ****************************************************
    // Helper functions
    // ****************************************************

    // Pointer steps between the two bytes of a register pair
    function automatic logic [2:0] pair_next(input logic [2:0] p);
        pair_next = {p[2:1], ~p[0]};
    endfunction : pair_next

    // ****************************************************
    // Reset release and pin synchronisers
    // ****************************************************
    logic rst_sync_n, scl_s, sda_s, addr_s;
    logic [LINES-1:0] pin_s;

    // Reset asserts at once, releases through two flops
    bit_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(1'b1),
        .sync_out(rst_sync_n)
    );

    // Bus idles high, so its synchronisers reset high;
    // 125 MHz sampling gives hundreds of samples per 400 kHz bit
    bit_sync #(.WIDTH(2), .RESET_VAL(1'b1)) u_bus_sync (
        .clk(clk),
        .rst_n(rst_sync_n),
        .async_in({scl_i, sda_i}),
        .sync_out({scl_s, sda_s})
    );

    // Address strap and port pins
    bit_sync #(.WIDTH(LINES + 1), .RESET_VAL(1'b0)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_sync_n),
        .async_in({addr_sel, port_in}),
        .sync_out({addr_s, pin_s})
    );

    // ****************************************************
    // Bus edge detection
    // ****************************************************
    logic scl_d, sda_d, scl_rise, scl_fall, bus_start, bus_stop;

    // Delayed copies for edge finding
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Start and stop are data edges while the clock is high
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign bus_start = scl_s && scl_d && sda_d && !sda_s;
    assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

    // ****************************************************
    // Register file
    // ****************************************************
    logic [7:0] cfg [2], outr [2], pol [2], snap [2];
    logic [7:0] shift_in, tx, load_byte;
    logic [2:0] ptr, load_ptr;
    logic [3:0] bit_cnt;
    logic rw, nack, wr_now, load_now, addr_hit;
    gpio_expander_pkg::slave_state_t state;

    // A byte is written at the clock fall that ends its eighth bit
    assign wr_now = scl_fall && (state == gpio_expander_pkg::ST_WR)
        && (bit_cnt == `BITS_PER_BYTE);

    // A byte is fetched after the address ack or a master ack
    assign load_now = scl_fall && (((state == gpio_expander_pkg::ST_ADDR_ACK) && rw)
        || ((state == gpio_expander_pkg::ST_RD_ACK) && !nack));
    assign load_ptr = (state == gpio_expander_pkg::ST_ADDR_ACK) ? ptr : pair_next(ptr);

    // Address select supplies bit zero of the slave address
    assign addr_hit = (shift_in[7:1] == {ADDR_BASE[6:1], addr_s});

    // Read multiplexer over every register
    always_comb begin
        unique case (load_ptr)
            `REG_IN0: load_byte = pin_s[7:0] ^ pol[0];
            `REG_IN1: load_byte = pin_s[15:8] ^ pol[1];
            `REG_OUT0: load_byte = outr[0];
            `REG_OUT1: load_byte = outr[1];
            `REG_POL0: load_byte = pol[0];
            `REG_POL1: load_byte = pol[1];
            `REG_CFG0: load_byte = cfg[0];
            `REG_CFG1: load_byte = cfg[1];
        endcase
    end

    // Writable registers; input registers ignore writes.
    // Output enables are the inverted direction bits, held in a flop.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg[0] <= `CFG_RESET;
            cfg[1] <= `CFG_RESET;
            outr[0] <= `OUT_RESET;
            outr[1] <= `OUT_RESET;
            pol[0] <= `POL_RESET;
            pol[1] <= `POL_RESET;
            port_oe <= '0;
            port_out <= {`OUT_RESET, `OUT_RESET};
        end else if (wr_now) begin
            unique case (ptr)
                `REG_OUT0: begin
                    outr[0] <= shift_in;
                    port_out[7:0] <= shift_in;
                end
                `REG_OUT1: begin
                    outr[1] <= shift_in;
                    port_out[15:8] <= shift_in;
                end
                `REG_POL0: pol[0] <= shift_in;
                `REG_POL1: pol[1] <= shift_in;
                `REG_CFG0: begin
                    cfg[0] <= shift_in;
                    port_oe[7:0] <= ~shift_in;
                end
                `REG_CFG1: begin
                    cfg[1] <= shift_in;
                    port_oe[15:8] <= ~shift_in;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************
    // Input capture and interrupt
    // ****************************************************
    logic [1:0] prime_cnt;
    logic [LINES-1:0] mismatch;

    // Snapshot is taken once the pin synchroniser has filled,
    // and again whenever the master reads an input register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prime_cnt <= 2'h0;
            snap[0] <= 8'h00;
            snap[1] <= 8'h00;
        end else if (prime_cnt != `PRIME_CYCLES) begin
            prime_cnt <= prime_cnt + 2'h1;
            snap[0] <= pin_s[7:0];
            snap[1] <= pin_s[15:8];
        end else if (load_now && (load_ptr == `REG_IN0)) begin
            snap[0] <= pin_s[7:0];
        end else if (load_now && (load_ptr == `REG_IN1)) begin
            snap[1] <= pin_s[15:8];
        end
    end

    // Only lines set as inputs can raise the interrupt
    assign mismatch = (pin_s ^ {snap[1], snap[0]}) & {cfg[1], cfg[0]};

    // Pull low while any input line differs; held off while priming so no pulse follows reset
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_n_oe <= 1'b0;
        end else begin
            int_n_oe <= (prime_cnt == `PRIME_CYCLES) && (|mismatch);
        end
    end

    // Open-drain pins only ever drive low
    assign int_n_o = 1'b0;
    assign sda_o = 1'b0;

    // ****************************************************
    // Serial slave sequencer
    // ****************************************************

    // Bit capture on rising clock, sampling master data or ack
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            shift_in <= 8'h00;
            nack <= 1'b0;
        end else if (scl_rise) begin
            shift_in <= {shift_in[6:0], sda_s};
            if (state == gpio_expander_pkg::ST_RD_ACK) begin
                nack <= sda_s;
            end
        end
    end

    // Bit counter: the ack is a ninth clock, so every data byte ends on eight
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bit_cnt <= 4'h0;
        end else if (bus_start) begin
            bit_cnt <= 4'h0;
        end else if (scl_fall && (bit_cnt == `BITS_PER_SLOT)) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && (state != gpio_expander_pkg::ST_IDLE)) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // Main state machine; data line changes only on clock fall.
    // Start or stop anywhere aborts the transfer cleanly.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= gpio_expander_pkg::ST_IDLE;
            sda_oe <= 1'b0;
            rw <= 1'b0;
            ptr <= `REG_IN0;
            tx <= 8'h00;
        end else if (bus_start) begin
            state <= gpio_expander_pkg::ST_ADDR;
            sda_oe <= 1'b0;
        end else if (bus_stop) begin
            state <= gpio_expander_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            unique case (state)
                gpio_expander_pkg::ST_IDLE: sda_oe <= 1'b0;
                gpio_expander_pkg::ST_ADDR: begin
                    if (bit_cnt == `BITS_PER_BYTE) begin
                        if (addr_hit) begin
                            rw <= shift_in[0];
                            sda_oe <= 1'b1;
                            state <= gpio_expander_pkg::ST_ADDR_ACK;
                        end else begin
                            state <= gpio_expander_pkg::ST_IDLE;
                        end
                    end
                end
                gpio_expander_pkg::ST_ADDR_ACK: begin
                    if (rw) begin
                        tx <= load_byte;
                        sda_oe <= ~load_byte[7];
                        state <= gpio_expander_pkg::ST_RD;
                    end else begin
                        sda_oe <= 1'b0;
                        state <= gpio_expander_pkg::ST_CMD;
                    end
                end
                gpio_expander_pkg::ST_CMD: begin
                    if (bit_cnt == `BITS_PER_BYTE) begin
                        ptr <= shift_in[2:0];
                        sda_oe <= 1'b1;
                        state <= gpio_expander_pkg::ST_CMD_ACK;
                    end
                end
                gpio_expander_pkg::ST_CMD_ACK: begin
                    sda_oe <= 1'b0;
                    state <= gpio_expander_pkg::ST_WR;
                end
                gpio_expander_pkg::ST_WR: begin
                    if (bit_cnt == `BITS_PER_BYTE) begin
                        sda_oe <= 1'b1;
                        state <= gpio_expander_pkg::ST_WR_ACK;
                    end
                end
                gpio_expander_pkg::ST_WR_ACK: begin
                    sda_oe <= 1'b0;
                    ptr <= pair_next(ptr);
                    state <= gpio_expander_pkg::ST_WR;
                end
                gpio_expander_pkg::ST_RD: begin
                    if (bit_cnt == `BITS_PER_BYTE) begin
                        sda_oe <= 1'b0;
                        state <= gpio_expander_pkg::ST_RD_ACK;
                    end else begin
                        tx <= {tx[6:0], 1'b0};
                        sda_oe <= ~tx[6];
                    end
                end
                gpio_expander_pkg::ST_RD_ACK: begin
                    if (nack) begin
                        sda_oe <= 1'b0;
                        state <= gpio_expander_pkg::ST_IDLE;
                    end else begin
                        ptr <= load_ptr;
                        tx <= load_byte;
                        sda_oe <= ~load_byte[7];
                        state <= gpio_expander_pkg::ST_RD;
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                    state <= gpio_expander_pkg::ST_IDLE;
                end
            endcase
        end
    end

endmodule : gpio_expander

`default_nettype wire

// >>> verif/gpio_expander_monitor.sv
// Port checker for the serial I/O expander
`timescale 1ns/1ps
`default_nettype none

module gpio_expander_monitor #(
    parameter int LINES = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic addr_sel,
    input wire logic [LINES-1:0] port_in,
    input wire logic [LINES-1:0] port_out,
    input wire logic [LINES-1:0] port_oe,
    input wire logic int_n_o,
    input wire logic int_n_oe
);
    logic [LINES-1:0] live;
    logic [LINES-1:0] prev;
    logic [3:0] quiet;

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    assign live = port_in & ~port_oe;

    // Cycles since an input line last moved; saturates so it never wraps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= {LINES{1'b0}};
            quiet <= 4'h0;
        end else begin
            prev <= live;
            if (live != prev) begin
                quiet <= 4'h0;
            end else if (quiet != 4'hf) begin
                quiet <= quiet + 4'h1;
            end
        end
    end

    // ********
    // Assertions
    // ********
    a_sda_open_drain: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    a_int_open_drain: assert property (int_n_o == 1'b0)
        else $error("interrupt pin driven high");
    a_reset_defaults: assert property ($rose(rst_n) |->
        port_oe == {LINES{1'b0}} && (&port_out) && !sda_oe && !int_n_oe)
        else $error("outputs not at reset values");
    a_dir_scl_low: assert property ($changed(port_oe) |-> !scl_i)
        else $error("direction moved outside a write");
    a_out_scl_low: assert property ($changed(port_out) |-> !scl_i)
        else $error("output latch moved outside a write");
    a_int_rise_cause: assert property ($rose(int_n_oe) |-> quiet < 4'h8)
        else $error("interrupt without input change");
    a_int_fall_cause: assert property ($fell(int_n_oe) |-> quiet < 4'h8 || !scl_i)
        else $error("interrupt cleared without cause");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data moved while clock high");
    a_sda_answer_time: assert property ($rose(sda_oe) |->
        !$past(scl_i) && $past(scl_i, 7))
        else $error("data pull-down late or early");
    a_int_quiet_reset: assert property ($rose(rst_n) |-> ##1 (!int_n_oe) [*8])
        else $error("interrupt pulse after reset");
endmodule : gpio_expander_monitor

bind gpio_expander gpio_expander_monitor #(.LINES(LINES)) mon (
    .clk(clk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .addr_sel(addr_sel),
    .port_in(port_in),
    .port_out(port_out),
    .port_oe(port_oe),
    .int_n_o(int_n_o),
    .int_n_oe(int_n_oe)
);
`default_nettype wire

// >>> verif/serial_master_model.sv
// Serial bus master model that drives the expander's link
`timescale 1ns/1ps
`default_nettype none

module serial_master_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    // Both lines released: the pull-ups hold them high between frames
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Quarter of a 160 ns link period; clock only moves inside frames
    task automatic q();
        repeat (5) @(posedge clk);
    endtask : q

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        sda_low <= 1'b0;
        q();
        scl_low <= 1'b0;
        q();
        sda_low <= 1'b1;
        q();
        scl_low <= 1'b1;
        q();
    endtask : start

    // Stop: data rises while the clock is high
    task automatic stop();
        sda_low <= 1'b1;
        q();
        scl_low <= 1'b0;
        q();
        sda_low <= 1'b0;
        q();
    endtask : stop

    // Eight bits then the acknowledge slot, first bit first; a 1 releases data
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low <= !tx[i];
            q();
            scl_low <= 1'b0;
            q();
            rx[i] = sda;
            q();
            scl_low <= 1'b1;
            q();
        end
    endtask : xfer
endmodule : serial_master_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the serial I/O expander
`timescale 1ns/1ps
`default_nettype none
`include "gpio_expander_defs.svh"

module tb;
    localparam logic [6:0] BASE = `ADDR_BASE_DEFAULT;
    logic clk = 1'b0;
    logic rst_n = 1'b1;
    logic addr_sel = 1'b0;
    logic [15:0] ext = 16'h81c3;
    logic [15:0] port_in;
    logic [15:0] port_out;
    logic [15:0] port_oe;
    logic sda_o, sda_oe, int_n_o, int_n_oe, scl_low, sda_low, scl_i, sda;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;

    // 125 MHz system clock
    always #4 clk = ~clk;

    // Pulled-up bus lines; a port line shows its own driver when enabled
    assign scl_i = !scl_low;
    assign sda = !(sda_low || sda_oe);
    assign port_in = (port_oe & port_out) | (~port_oe & ext);

    gpio_expander dut (
        .clk(clk),
        .rst_n(rst_n),
        .scl_i(scl_i),
        .sda_i(sda),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .addr_sel(addr_sel),
        .port_in(port_in),
        .port_out(port_out),
        .port_oe(port_oe),
        .int_n_o(int_n_o),
        .int_n_oe(int_n_oe)
    );

    serial_master_model m (
        .clk(clk),
        .sda(sda),
        .scl_low(scl_low),
        .sda_low(sda_low)
    );

    // ********
    // Access tasks
    // ********
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic put(input logic [7:0] b, input logic acked);
        logic [8:0] rx;
        m.xfer({b, 1'b1}, rx);
        chk(16'(rx[0]), 16'(!acked));
    endtask : put

    task automatic wr(input logic [2:0] p, input logic [7:0] d);
        m.start();
        put({BASE[6:1], addr_sel, 1'b0}, 1'b1);
        put({5'h00, p}, 1'b1);
        put(d, 1'b1);
        m.stop();
    endtask : wr

    // Reads the pointed register and its partner; result is {partner, first}
    task automatic rd(input logic [2:0] p, input logic [15:0] exp);
        logic [8:0] r0;
        logic [8:0] r1;
        m.start();
        put({BASE[6:1], addr_sel, 1'b0}, 1'b1);
        put({5'h00, p}, 1'b1);
        m.start();
        put({BASE[6:1], addr_sel, 1'b1}, 1'b1);
        m.xfer(9'h1fe, r0);
        m.xfer(9'h1ff, r1);
        m.stop();
        chk({r1[8:1], r0[8:1]}, exp);
    endtask : rd

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // Cut a hung run short; the sequence needs about 16300 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk(port_oe, 16'h0000);
        chk(port_out, 16'hffff);
        rd(`REG_CFG0, 16'hffff);
        rd(`REG_OUT0, 16'hffff);
        rd(`REG_POL0, 16'h0000);
        rd(`REG_IN0, 16'h81c3);
        wr(`REG_POL1, 8'h3c);
        wr(`REG_CFG0, 8'h0f);
        wr(`REG_OUT0, 8'h5a);
        chk(port_oe, 16'h00f0);
        chk(port_out, 16'hff5a);
        rd(`REG_IN0, 16'hbd53);
        rd(`REG_POL0, 16'h3c00);
        rd(`REG_CFG0, 16'hff0f);
        ext <= 16'h81c2;
        repeat (8) @(posedge clk);
        chk(16'(int_n_oe), 16'h0001);
        ext <= 16'h81c3;
        repeat (8) @(posedge clk);
        chk(16'(int_n_oe), 16'h0000);
        ext <= 16'h80c3;
        repeat (8) @(posedge clk);
        chk(16'(int_n_oe), 16'h0001);
        rd(`REG_OUT0, 16'hff5a);
        chk(16'(int_n_oe), 16'h0001);
        rd(`REG_IN1, 16'h53bc);
        chk(16'(int_n_oe), 16'h0000);
        addr_sel <= 1'b1;
        repeat (4) @(posedge clk);
        m.start();
        put({BASE[6:1], 1'b0, 1'b0}, 1'b0);
        m.stop();
        rd(`REG_OUT0, 16'hff5a);
        // Input register ignores writes; a two-byte write steps to the partner
        wr(`REG_IN0, 8'h00);
        m.start();
        put({BASE[6:1], addr_sel, 1'b0}, 1'b1);
        put({5'h00, `REG_OUT1}, 1'b1);
        put(8'ha5, 1'b1);
        put(8'h3c, 1'b1);
        m.stop();
        wr(`REG_CFG1, 8'h00);
        chk(port_out, 16'ha53c);
        chk(port_oe, 16'hfff0);
        rd(`REG_IN0, 16'h9933);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(port_oe, 16'h0000);
        chk(port_out, 16'hffff);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        rd(`REG_POL0, 16'h0000);
        rd(`REG_CFG0, 16'hffff);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
